// [include/serial_tx_params.svh]
// Purpose: Offsets, field positions, reset values and timing counts of the serial transmitter
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes:   Constants only; types live in serial_tx_pkg
`ifndef SERIAL_TX_PARAMS_SVH
`define SERIAL_TX_PARAMS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFS_TX_CTRL     12'h000
`define OFS_RX_CTRL     12'h004
`define OFS_RATE_CTRL   12'h008
`define OFS_RATE_DIV    12'h00C
`define OFS_TX_BUF      12'h010

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define TXC_NINTH_BIT   0
`define TXC_SHIFT_EMPTY 1
`define TXC_BREAK_SEND  3
`define TXC_SYNC_MODE   4
`define TXC_TX_ENABLE   5
`define TXC_NINE_SEL    6
`define TXC_BUF_FREE    8
`define RXC_PORT_EN     7
`define RTC_DIV16       3
`define RTC_POL_INV     4

// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define RST_RATE_DIV    16'h0000
`define BREAK_BITS      4'hD
`define TRANSFER_CYCLES 1

`endif

// [include/serial_tx_pkg.sv]
// Purpose: Types shared by the serial transmitter files
// Assumes: Included after serial_tx_params.svh
// Notes:   Shifter states and the control bundle
package serial_tx_pkg;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_START = 3'b001,
      ST_DATA  = 3'b010,
      ST_STOP  = 3'b011,
      ST_BREAK = 3'b100
   } shift_state_e;

   // Software control bits that steer the transmitter
   typedef struct packed {
      logic nine_bit_transmit_select;
      logic ninth_transmit_bit;
      logic transmit_enable_bit;
      logic sync_mode;
      logic port_enable_bit;
      logic output_polarity_invert;
      logic div16_select;
      logic break_request;
   } tx_ctrl_s;

endpackage

// [design/baud_tick_gen.sv]
// Purpose: Baud divider producing one tick per bit period
// Assumes: Divider value from software; 8-bit mode uses the low byte only
// Notes:   Restarts on sync so the first bit after a load is full length
`timescale 1ns/1ps
module baud_tick_gen #(
   parameter int DIV_W = 16
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             sync,
   input  wire logic             div16_select,
   input  wire logic [DIV_W-1:0] divisor,
   output logic                  tick
);

   logic [DIV_W-1:0] cnt_q;
   logic [DIV_W-1:0] limit;

   // ----------------------------------------------
   // Divider of the system clock
   // ----------------------------------------------
   assign limit = div16_select ? divisor : {{(DIV_W-8){1'b0}}, divisor[7:0]};
   assign tick  = (cnt_q == limit) && !sync;

   // Counts limit+1 clocks per bit period
   always_ff @(posedge aclk) begin
      if (!aresetn || sync || tick) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

endmodule

// [design/serial_tx.sv]
// Purpose: Asynchronous NRZ serial transmitter with one-deep buffer and AXI4-Lite registers
// Assumes: Single clock aclk, synchronous active-low reset, receiver lives elsewhere
// Notes:   Unmapped addresses answer OKAY with zero data; writes ignore byte strobes
//          except lane 0 and 1 where fields live
`timescale 1ns/1ps
`include "serial_tx_params.svh"
module serial_tx #(
   parameter int DIV_W = 16
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             transmit_pin_o,
   output logic             transmit_pin_oe,
   output logic             transmit_buffer_free_flag
);

   // ---------------------------------------------------------------
   // Register storage
   // ---------------------------------------------------------------
   serial_tx_pkg::tx_ctrl_s      ctrl_q;
   logic [DIV_W-1:0]             divisor_q;
   logic [7:0]                   transmit_buffer_q;
   logic                         buf_full_q;
   logic [8:0]                   transmit_shifter_q;
   serial_tx_pkg::shift_state_e  state_q;
   logic [3:0]                   bit_cnt_q;
   logic                         line_q;
   logic                         flag_valid_q;

   // AXI write and read side holding
   logic [11:0] aw_addr_q;
   logic        aw_have_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        w_have_q;
   logic        bvalid_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;

   // ---------------------------------------------------------------
   // Derived control
   // ---------------------------------------------------------------
   logic async_active;
   logic tx_idle;
   logic load_shifter;
   logic tick;
   logic wr_fire;
   logic wr_buf;
   logic wr_txc;
   logic wr_rxc;
   logic wr_rtc;
   logic wr_div;
   logic last_data;
   logic shifter_empty_status;

   // Transmit path enabled only in async mode with both enables
   assign async_active = ctrl_q.transmit_enable_bit && !ctrl_q.sync_mode
                         && ctrl_q.port_enable_bit;
   assign tx_idle      = (state_q == serial_tx_pkg::ST_IDLE);
   // Waiting character moves in as soon as the shifter is idle again
   assign load_shifter = async_active && buf_full_q && tx_idle;
   assign shifter_empty_status = tx_idle;
   assign last_data    = (bit_cnt_q == (ctrl_q.nine_bit_transmit_select ? 4'h8 : 4'h7));

   // Write decode
   assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
   assign wr_txc  = wr_fire && (aw_addr_q == `OFS_TX_CTRL);
   assign wr_rxc  = wr_fire && (aw_addr_q == `OFS_RX_CTRL);
   assign wr_rtc  = wr_fire && (aw_addr_q == `OFS_RATE_CTRL);
   assign wr_div  = wr_fire && (aw_addr_q == `OFS_RATE_DIV);
   assign wr_buf  = wr_fire && (aw_addr_q == `OFS_TX_BUF) && w_strb_q[0];

   // ---------------------------------------------------------------
   // Baud divider
   // ---------------------------------------------------------------
   baud_tick_gen #(
      .DIV_W(DIV_W)
   ) u_baud (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .sync         (tx_idle),
      .div16_select (ctrl_q.div16_select),
      .divisor      (divisor_q),
      .tick         (tick)
   );

   // ---------------------------------------------------------------
   // AXI4-Lite write channel
   // ---------------------------------------------------------------
   assign s_axi_awready = !aw_have_q;
   assign s_axi_wready  = !w_have_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = 2'h0;

   // Address and data may arrive in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= 12'h000;
      end else if (s_axi_awvalid && !aw_have_q) begin
         aw_have_q <= 1'b1;
         aw_addr_q <= {s_axi_awaddr[11:2], 2'h0};
      end else if (wr_fire) begin
         aw_have_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else if (s_axi_wvalid && !w_have_q) begin
         w_have_q <= 1'b1;
         w_data_q <= s_axi_wdata;
         w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_have_q <= 1'b0;
      end
   end

   // Response one cycle after both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   // Break request self-clears once the break frame has started
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q    <= '0;           // Polarity resets to high-true
         divisor_q <= `RST_RATE_DIV;
      end else begin
         if (wr_txc && w_strb_q[0]) begin
            ctrl_q.ninth_transmit_bit       <= w_data_q[`TXC_NINTH_BIT];
            ctrl_q.sync_mode                <= w_data_q[`TXC_SYNC_MODE];
            ctrl_q.transmit_enable_bit      <= w_data_q[`TXC_TX_ENABLE];
            ctrl_q.nine_bit_transmit_select <= w_data_q[`TXC_NINE_SEL];
            ctrl_q.break_request            <= w_data_q[`TXC_BREAK_SEND];
         end else if (state_q == serial_tx_pkg::ST_BREAK) begin
            ctrl_q.break_request <= 1'b0;
         end
         if (wr_rxc && w_strb_q[0]) begin
            ctrl_q.port_enable_bit <= w_data_q[`RXC_PORT_EN];
         end
         if (wr_rtc && w_strb_q[0]) begin
            ctrl_q.div16_select           <= w_data_q[`RTC_DIV16];
            ctrl_q.output_polarity_invert <= w_data_q[`RTC_POL_INV];
         end
         if (wr_div) begin
            if (w_strb_q[0]) divisor_q[7:0]       <= w_data_q[7:0];
            if (w_strb_q[1]) divisor_q[DIV_W-1:8] <= w_data_q[DIV_W-1:8];
         end
      end
   end

   // ---------------------------------------------------------------
   // Transmit buffer
   // ---------------------------------------------------------------
   // A write while full overwrites the waiting character
   always_ff @(posedge aclk) begin
      if (!aresetn || !ctrl_q.transmit_enable_bit) begin
         buf_full_q        <= 1'b0;
         transmit_buffer_q <= 8'h00;
      end else if (wr_buf) begin
         buf_full_q        <= 1'b1;
         transmit_buffer_q <= w_data_q[7:0];
      end else if (load_shifter) begin
         buf_full_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Shifter state machine
   // ---------------------------------------------------------------
   // One tick per bit keeps each level for one bit period; a stop bit with the next character waiting lasts one clock more, for the idle cycle
   always_ff @(posedge aclk) begin
      if (!aresetn || !async_active) begin
         state_q            <= serial_tx_pkg::ST_IDLE;
         transmit_shifter_q <= 9'h000;
         bit_cnt_q          <= 4'h0;
         line_q             <= 1'b1;
      end else begin
         case (state_q)
            serial_tx_pkg::ST_IDLE: begin
               line_q <= 1'b1;
               if (load_shifter) begin
                  // Ninth bit sampled at transfer time
                  transmit_shifter_q <= {ctrl_q.ninth_transmit_bit,
                                         transmit_buffer_q};
                  bit_cnt_q <= 4'h0;
                  line_q    <= 1'b0; // Start bit right after transfer
                  state_q   <= ctrl_q.break_request ? serial_tx_pkg::ST_BREAK
                                                    : serial_tx_pkg::ST_START;
               end
            end
            serial_tx_pkg::ST_START: begin
               if (tick) begin
                  line_q  <= transmit_shifter_q[0];
                  state_q <= serial_tx_pkg::ST_DATA;
               end
            end
            serial_tx_pkg::ST_DATA: begin
               if (tick) begin
                  if (last_data) begin
                     line_q  <= 1'b1; // Single stop bit at mark
                     state_q <= serial_tx_pkg::ST_STOP;
                  end else begin
                     transmit_shifter_q <= {1'b0, transmit_shifter_q[8:1]};
                     line_q             <= transmit_shifter_q[1];
                     bit_cnt_q          <= bit_cnt_q + 4'h1;
                  end
               end
            end
            serial_tx_pkg::ST_STOP: begin
               if (tick) begin
                  state_q <= serial_tx_pkg::ST_IDLE;
               end
            end
            serial_tx_pkg::ST_BREAK: begin
               // Start bit plus twelve space bits, then the stop bit
               if (tick) begin
                  if (bit_cnt_q == `BREAK_BITS - 4'h1) begin
                     line_q  <= 1'b1;
                     state_q <= serial_tx_pkg::ST_STOP;
                  end else begin
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  end
               end
            end
            default: begin
               state_q <= serial_tx_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Pin drive
   // ---------------------------------------------------------------
   // Polarity applies only in async mode; pin released when not enabled
   assign transmit_pin_o  = (ctrl_q.output_polarity_invert && !ctrl_q.sync_mode)
                            ? !line_q : line_q;
   assign transmit_pin_oe = ctrl_q.port_enable_bit && ctrl_q.transmit_enable_bit;

   // ---------------------------------------------------------------
   // Buffer-free flag
   // ---------------------------------------------------------------
   // Flag settles on the second cycle after a buffer write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_valid_q <= 1'b0;
      end else begin
         flag_valid_q <= ctrl_q.transmit_enable_bit && !buf_full_q;
      end
   end
   // Enable raises the flag at once since the buffer is empty then
   assign transmit_buffer_free_flag = ctrl_q.transmit_enable_bit
                                      && (!buf_full_q || flag_valid_q) && !wr_buf;

   // ---------------------------------------------------------------
   // AXI4-Lite read channel
   // ---------------------------------------------------------------
   logic [31:0] rd_mux;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = 2'h0;
   assign s_axi_rdata   = rdata_q;
   assign rd_mux =
      (s_axi_araddr[11:2] == `OFS_TX_CTRL >> 2) ?
         {23'h0, transmit_buffer_free_flag, 1'b0, ctrl_q.nine_bit_transmit_select,
          ctrl_q.transmit_enable_bit, ctrl_q.sync_mode, ctrl_q.break_request, 1'b0,
          shifter_empty_status, ctrl_q.ninth_transmit_bit} :
      (s_axi_araddr[11:2] == `OFS_RX_CTRL >> 2) ? {24'h0, ctrl_q.port_enable_bit, 7'h00} :
      (s_axi_araddr[11:2] == `OFS_RATE_CTRL >> 2) ?
         {27'h0, ctrl_q.output_polarity_invert, ctrl_q.div16_select, 3'h0} :
      (s_axi_araddr[11:2] == `OFS_RATE_DIV >> 2) ? {{(32-DIV_W){1'b0}}, divisor_q} :
      32'h0000_0000;

   // Read data registered; buffer reads as zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
      end else if (s_axi_arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_mux;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

endmodule

// [sim/serial_tx_assertions.sv]
// Purpose: Port-level checks of the serial transmitter
// Assumes: Single clock aclk, synchronous active-low reset
// Notes:   Bus timing follows the hand-over write and read walks
`timescale 1ns/1ps
module serial_tx_assertions (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        transmit_pin_o,
   input wire logic        transmit_pin_oe,
   input wire logic        transmit_buffer_free_flag
);
   // ----------------------------------------
   // Sequences and properties
   // ----------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence aw_w_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence write_answer;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   a_write_answer: assert property (aw_w_taken |=> write_answer)
      else $error("write response late or early");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_aw_slot_full: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("address slot took a second item");
   a_w_slot_full: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
      else $error("data slot took a second item");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   a_bvalid_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   a_bresp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
      else $error("write response not okay");
   a_rresp_okay: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0)
      else $error("read response not okay");
   a_reset_idle: assert property (disable iff (1'h0) !aresetn |=>
      transmit_pin_o && !transmit_pin_oe && !transmit_buffer_free_flag)
      else $error("pin or flag wrong after reset");
endmodule
bind serial_tx serial_tx_assertions serial_tx_assertions_inst (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .transmit_pin_o(transmit_pin_o), .transmit_pin_oe(transmit_pin_oe),
   .transmit_buffer_free_flag(transmit_buffer_free_flag));

// [sim/serial_rx_model.sv]
// Purpose: Remote receiver that decodes frames from the serial line
// Assumes: Bit period in clocks given by the bench
// Notes:   Reports {break, ninth, data}; a bad stop that is no break gives 3FF
`timescale 1ns/1ps
module serial_rx_model (
   input  wire logic        aclk,
   input  wire logic        line,
   input  wire logic        inv,
   input  wire logic        nine,
   input  wire logic [15:0] per,
   output logic             rx_valid,
   output logic [9:0]       rx_frame
);
   logic        lvl;
   logic [15:0] run = 16'h0;
   logic [15:0] last_run = 16'h0;
   // Undo the polarity so the decoder always sees mark as one
   assign lvl = line ^ inv;
   // Space stretch length, kept so a break can be told from a bad frame
   always @(posedge aclk) begin
      if (lvl === 1'h0) begin
         run <= run + 16'h1;
      end else begin
         if (run != 16'h0) last_run <= run;
         run <= 16'h0;
      end
   end
   // Mid-bit sampling; a start that drifts shows up as wrong data
   initial begin : rx
      logic [8:0] d;
      int         i;
      rx_valid = 1'h0;
      rx_frame = 10'h0;
      forever begin
         @(posedge aclk);
         rx_valid <= 1'h0;
         if (lvl === 1'h0) begin
            d = 9'h0;
            repeat (per / 2) @(posedge aclk);
            for (i = 0; i < (nine ? 9 : 8); i++) begin
               repeat (per) @(posedge aclk);
               d[i] = lvl;
            end
            repeat (per) @(posedge aclk);
            if (lvl === 1'h1) begin
               rx_frame <= {1'h0, d};
            end else begin
               for (i = 0; i < 40 && lvl !== 1'h1; i++) repeat (per) @(posedge aclk);
               @(posedge aclk);
               rx_frame <= (last_run == 16'(13 * per)) ? 10'h200 : 10'h3FF;
            end
            rx_valid <= 1'h1;
         end
      end
   end
endmodule

// [sim/serial_tx_tb.sv]
// Purpose: Self-checking bench of the serial transmitter
// Assumes: Receiver model on the line, AXI4-Lite master tasks
// Notes:   Frames are noted in a queue and matched as the model reports them
`timescale 1ns/1ps
`include "serial_tx_params.svh"
module serial_tx_tb;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        transmit_pin_o, transmit_pin_oe, transmit_buffer_free_flag;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        inv, nine, mon_on, line_w, rx_valid;
   logic [15:0] per;
   logic [9:0]  rx_frame;
   logic [9:0]  exp_q[$];
   int          num_errors, n_tests, seed;
   // Released pin is pulled to the idle level
   assign line_w = transmit_pin_oe ? transmit_pin_o : ~inv;
   initial begin
      aclk = 1'h0;
      forever #12.5 aclk = ~aclk;
   end
   serial_tx serial_tx_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .transmit_pin_o(transmit_pin_o),
      .transmit_pin_oe(transmit_pin_oe),
      .transmit_buffer_free_flag(transmit_buffer_free_flag));
   serial_rx_model serial_rx_model_inst (.aclk(aclk), .line(line_w), .inv(inv),
      .nine(nine), .per(per), .rx_valid(rx_valid), .rx_frame(rx_frame));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask
   task automatic hang(input string nm);
      chk(nm, 32'h1, 32'h0);
      report_and_stop();
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // Address and data offered together, each released once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1'h1;
      s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid === 1'h1) break;
      end
      s_axi_bready <= 1'h0;
      if (k == 50) hang("write");
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      int k;
      @(posedge aclk);
      s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1;
      d = 32'h0;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid === 1'h1) begin d = s_axi_rdata; break; end
      end
      s_axi_rready <= 1'h0;
      if (k == 50) hang("read");
   endtask
   // Waits for room so a queued character is never overwritten
   task automatic send(input logic [9:0] e, input logic [7:0] d);
      int k;
      for (k = 0; k < 3000 && transmit_buffer_free_flag !== 1'h1; k++) @(posedge aclk);
      if (k == 3000) hang("buffer free");
      exp_q.push_back(e);
      wr(`OFS_TX_BUF, {24'h0, d});
   endtask
   task automatic drain(input string nm);
      int k;
      for (k = 0; k < 20000 && exp_q.size() != 0; k++) @(posedge aclk);
      if (k == 20000) hang("drain");
      cyc(per);
      $display("test %s done", nm);
   endtask
   // Oldest note is matched against every frame the receiver reports while mon_on is set
   always @(posedge aclk) begin
      if (rx_valid === 1'h1 && mon_on) begin
         if (exp_q.size() == 0) chk("frame", 32'h400, {22'h0, rx_frame});
         else chk("frame", {22'h0, exp_q.pop_front()}, {22'h0, rx_frame});
      end
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin : main
      logic [31:0] r;
      logic [7:0]  d;
      int          i, k;
      seed = 2; num_errors = 0; n_tests = 0; aresetn = 1'h0; s_axi_wstrb = 4'hF;
      s_axi_awaddr = 12'h0; s_axi_awvalid = 1'h0; s_axi_wdata = 32'h0; s_axi_wvalid = 1'h0;
      s_axi_bready = 1'h0; s_axi_araddr = 12'h0; s_axi_arvalid = 1'h0; s_axi_rready = 1'h0;
      inv = 1'h0; nine = 1'h0; mon_on = 1'h1; per = 16'h0006;
      cyc(3);
      aresetn <= 1'h1;
      cyc(1);
      chk("idle", 32'h1, {31'h0, transmit_pin_o});
      chk("oe", 32'h0, {31'h0, transmit_pin_oe});
      wr(`OFS_RATE_DIV, 32'h0105);
      wr(`OFS_RX_CTRL, 32'h80);
      cyc(2);
      chk("oe", 32'h0, {31'h0, transmit_pin_oe});
      wr(`OFS_TX_CTRL, 32'h20);
      cyc(2);
      chk("oe", 32'h1, {31'h0, transmit_pin_oe});
      chk("flag", 32'h1, {31'h0, transmit_buffer_free_flag});
      $display("test enable done");
      // Back-to-back characters, the high divider byte ignored in 8-bit mode
      for (i = 0; i < 4; i++) begin
         d = 8'($random(seed));
         send({2'h0, d}, d);
         if (i == 0) begin
            for (k = 0; k < 4 && transmit_pin_o !== 1'h0; k++) @(posedge aclk);
            chk("start", 32'h0, {31'h0, transmit_pin_o});
         end else begin
            cyc(2);
            chk("flag", 32'h0, {31'h0, transmit_buffer_free_flag});
            rd(`OFS_TX_CTRL, r);
            chk("empty", 32'h0, {31'h0, r[1]});
         end
      end
      drain("burst");
      rd(`OFS_TX_CTRL, r);
      chk("status", 32'h122, r);
      nine <= 1'h1;
      for (i = 0; i < 2; i++) begin
         wr(`OFS_TX_CTRL, 32'h60 | i);
         d = 8'($random(seed));
         send({1'h0, i[0], d}, d);
         drain("nine");
      end
      nine <= 1'h0;
      wr(`OFS_TX_CTRL, 32'h20);
      // Polarity flip makes a false start on the line, so matching pauses
      mon_on <= 1'h0;
      inv <= 1'h1;
      wr(`OFS_RATE_CTRL, 32'h10);
      cyc(80);
      mon_on <= 1'h1;
      chk("idle inv", 32'h0, {31'h0, transmit_pin_o});
      d = 8'($random(seed));
      send({2'h0, d}, d);
      drain("invert");
      wr(`OFS_RATE_CTRL, 32'h18);
      per <= 16'h0106;
      d = 8'($random(seed));
      send({2'h0, d}, d);
      drain("divider16");
      wr(`OFS_RATE_CTRL, 32'h10);
      per <= 16'h0006;
      wr(`OFS_TX_CTRL, 32'h28);
      send(10'h200, 8'($random(seed)));
      drain("break");
      rd(`OFS_TX_CTRL, r);
      chk("break clear", 32'h0, {31'h0, r[3]});
      rd(12'h040, r);
      chk("unmapped", 32'h0, r);
      rd(`OFS_TX_BUF, r);
      chk("buffer read", 32'h0, r);
      // Disable in mid-frame; whatever the receiver makes of it is ignored
      mon_on <= 1'h0;
      wr(`OFS_TX_BUF, 32'hA5);
      cyc(10);
      wr(`OFS_TX_CTRL, 32'h0);
      cyc(2);
      chk("oe off", 32'h0, {31'h0, transmit_pin_oe});
      chk("flag off", 32'h0, {31'h0, transmit_buffer_free_flag});
      $display("test abort done");
      report_and_stop();
   end
endmodule
